// >>> core/spi_cfg_pkg.sv
// package: register offsets, field positions, reset values, carriers
// assumes: used by the serial configuration slice and its helpers
package spi_cfg_pkg;

    // -----------------------------------------------------------------
    // register map
    // -----------------------------------------------------------------
    localparam logic [7:0]  OFS_PHASE_CTRL  = 8'h00;
    localparam logic [7:0]  OFS_CONTROL     = 8'h04;
    localparam logic [7:0]  OFS_IRQ_STATUS  = 8'h10;
    localparam logic [7:0]  OFS_IRQ_MASK    = 8'h14;
    localparam logic [7:0]  OFS_FLAG_VIEW   = 8'h18;

    localparam logic [31:0] RST_CTRL_FIRST  = 32'h0000_0000;
    localparam logic [31:0] RST_CTRL_SECOND = 32'h0000_0700;
    localparam logic [31:0] CTRL_WR_MASK    = 32'h0000_7FFF;

    // -----------------------------------------------------------------
    // control field positions
    // -----------------------------------------------------------------
    localparam int B_TX_ODD   = 14;
    localparam int B_RX_ODD   = 13;
    localparam int B_BYTE_ACC = 12;
    localparam int B_SIZE_LO  = 8;
    localparam int B_TBE_IE   = 7;
    localparam int B_RECEIVE_NOT_EMPTY_FLAG_IE  = 6;
    localparam int B_ERR_IE   = 5;
    localparam int B_ALT_FMT  = 4;
    localparam int B_SEL_PULS = 3;
    localparam int B_SEL_DRV  = 2;
    localparam int B_TX_DMA   = 1;
    localparam int B_RX_DMA   = 0;
    localparam int B_PHASE    = 0;
    localparam int B_UNIT_EN  = 1;

    localparam logic [3:0] SIZE_MIN_CODE = 4'h3;
    localparam logic [3:0] SIZE_FORCED   = 4'h7;
    localparam logic [3:0] SIZE_MERGE    = 4'h7;

    localparam logic [1:0] LVL_EMPTY   = 2'h0;
    localparam logic [1:0] LVL_QUARTER = 2'h1;
    localparam logic [1:0] LVL_HALF    = 2'h2;
    localparam logic [1:0] LVL_FULL    = 2'h3;

    // -----------------------------------------------------------------
    // sticky event bits
    // -----------------------------------------------------------------
    localparam int EV_TBE    = 0;
    localparam int EV_RECEIVE_NOT_EMPTY_FLAG   = 1;
    localparam int EV_ERR    = 2;
    localparam int EV_FMT    = 3;
    localparam int EV_WIDTH  = 4;

    typedef struct packed {
        logic       tx_dma_odd_count;
        logic       rx_dma_odd_count;
        logic       byte_access_select;
        logic [3:0] frame_size_field;
        logic       transmit_empty_irq_enable;
        logic       receive_not_empty_irq_enable;
        logic       error_irq_enable;
        logic       alt_frame_format_enable;
        logic       select_pulse_enable;
        logic       select_output_drive;
        logic       tx_dma_request_enable;
        logic       rx_dma_request_enable;
    } ctrl_s;

    typedef struct packed {
        logic checksum_mismatch_flag;
        logic config_fault_flag;
        logic frame_format_error_flag;
        logic receive_overrun_flag;
        logic transmit_underrun_flag;
    } err_s;

endpackage

// >>> core/fifo_level_code.sv
// holds: fifo fill amount to 2-bit level code
// assumes: count is the stored amount of a fifo of DEPTH entries
`timescale 1ns/1ps
module fifo_level_code
    import spi_cfg_pkg::*;
#(
    parameter int DEPTH = 4,
    parameter int CW    = 3
)(
    input  wire logic [CW-1:0] count,
    output wire logic [1:0]    level
);
    // ---------------------------------------------------------------
    // level decode
    // ---------------------------------------------------------------
    localparam logic [CW:0] HALF_X2 = (CW+1)'(DEPTH);
    wire logic        is_empty = (count == '0);
    wire logic        above    = ({count, 1'b0} > HALF_X2);
    wire logic        at_half  = ({count, 1'b0} == HALF_X2);

    assign level = is_empty ? LVL_EMPTY   :
                   above    ? LVL_FULL    :
                   at_half  ? LVL_HALF    : LVL_QUARTER;
endmodule

// >>> core/ws_edge_monitor.sv
// holds: synchroniser and edge finder for an external line
// assumes: line comes from outside the pclk domain
`timescale 1ns/1ps
module ws_edge_monitor (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic line_in,
    output wire logic line_sync,
    output wire logic rise,
    output wire logic fall
);
    // ---------------------------------------------------------------
    // two-flop synchroniser, then edge detect
    // ---------------------------------------------------------------
    logic meta_q;
    logic sync_q;
    logic prev_q;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
            prev_q <= 1'b0;
        end
        else
        begin
            meta_q <= line_in;
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    assign line_sync = sync_q;
    assign rise      = sync_q & ~prev_q;
    assign fall      = ~sync_q & prev_q;
endmodule

// >>> core/spi_ctl_interrupt_dma_config.sv
// holds: control slice of the serial unit: phase, control word,
// interrupt and dma request generation, apb register slave
// assumes: flags come from the shift engine on pclk; serial clock and
// word select come from pins and are synchronised here
//
// Design decision made here: the APB slave port.
`timescale 1ns/1ps

module spi_ctl_interrupt_dma_config
    import spi_cfg_pkg::*;
#(
    parameter bit SECOND_INSTANCE = 1'b1,
    parameter int FIFO_DEPTH      = 4,
    parameter int CW              = 3
)(
    input  wire logic          pclk,
    input  wire logic          presetn,
    input  wire logic          psel,
    input  wire logic          penable,
    input  wire logic          pwrite,
    input  wire logic [7:0]    paddr,
    input  wire logic [31:0]   pwdata,
    output logic      [31:0]   prdata,
    output logic               pready,
    output logic               pslverr,
    input  wire logic          serial_clk_pin,
    input  wire logic          word_select_line,
    input  wire logic          slave_audio_mode,
    input  wire logic          data_write_16,
    input  wire logic          tx_buf_empty,
    input  wire logic [CW-1:0] rx_fifo_count,
    input  wire logic [CW-1:0] tx_fifo_count,
    input  wire logic [4:0]    err_flags_in,
    output logic               capture_strobe,
    output logic [3:0]         frame_bits_m1,
    output logic [1:0]         rx_fifo_level,
    output logic [1:0]         tx_fifo_level,
    output logic               receive_not_empty_flag,
    output logic               transmit_empty_flag,
    output logic               frame_format_error_flag,
    output logic               tx_odd_active,
    output logic               rx_odd_active,
    output logic               alt_frame_format,
    output logic               select_pulse_mode,
    output logic               select_out_n,
    output logic               select_oe_n,
    output logic               tx_dma_req,
    output logic               rx_dma_req,
    output logic               irq
);
    // ---------------------------------------------------------------
    // registers
    // ---------------------------------------------------------------
    localparam logic [31:0] CTRL_RST =
        SECOND_INSTANCE ? RST_CTRL_SECOND : RST_CTRL_FIRST;

    ctrl_s                ctrl_q;
    logic                 phase_q;
    logic                 unit_en_q;
    logic [EV_WIDTH-1:0]  stat_q;
    logic [EV_WIDTH-1:0]  mask_q;
    logic                 fmt_err_q;

    err_s err_in;
    assign err_in = err_s'(err_flags_in);

    // ---------------------------------------------------------------
    // bus decode
    // ---------------------------------------------------------------
    wire logic wr_en    = psel & penable & pwrite;
    wire logic hit_ph   = (paddr == OFS_PHASE_CTRL);
    wire logic hit_ctl  = (paddr == OFS_CONTROL);
    wire logic hit_st   = (paddr == OFS_IRQ_STATUS);
    wire logic hit_mk   = (paddr == OFS_IRQ_MASK);
    wire logic hit_fv   = (paddr == OFS_FLAG_VIEW);
    wire logic mapped   = hit_ph | hit_ctl | hit_st | hit_mk | hit_fv;

    // ---------------------------------------------------------------
    // derived flags
    // ---------------------------------------------------------------
    wire logic [1:0] rx_lvl;
    wire logic [1:0] tx_lvl;

    fifo_level_code #(.DEPTH(FIFO_DEPTH), .CW(CW)) u_rx_lvl (
        .count (rx_fifo_count),
        .level (rx_lvl)
    );
    fifo_level_code #(.DEPTH(FIFO_DEPTH), .CW(CW)) u_tx_lvl (
        .count (tx_fifo_count),
        .level (tx_lvl)
    );

    wire logic [CW-1:0] rx_thr =
        ctrl_q.byte_access_select ? CW'(1) : CW'(2);
    wire logic receive_not_empty_flag_w  = SECOND_INSTANCE ?
                         (rx_fifo_count >= rx_thr) :
                         (rx_fifo_count != '0);
    wire logic tbe_w   = SECOND_INSTANCE ?
                         (tx_fifo_count == '0) : tx_buf_empty;
    wire logic err_any = (|err_in) | fmt_err_q;

    // code 0011 and up pass, lower codes read as 8 bits
    function automatic logic [3:0] eff_size(input logic [3:0] code);
        eff_size = (code < SIZE_MIN_CODE) ? SIZE_FORCED : code;
    endfunction
    wire logic [3:0] size_eff = eff_size(ctrl_q.frame_size_field);
    wire logic merge_mode = SECOND_INSTANCE & data_write_16 &
                            (size_eff <= SIZE_MERGE);

    // ---------------------------------------------------------------
    // serial clock edge finding and word select check
    // ---------------------------------------------------------------
    wire logic sclk_s;
    wire logic sclk_rise;
    wire logic sclk_fall;
    wire logic ws_rise;
    wire logic ws_fall;

    ws_edge_monitor u_sclk (
        .pclk      (pclk),
        .presetn   (presetn),
        .line_in   (serial_clk_pin),
        .line_sync (sclk_s),
        .rise      (sclk_rise),
        .fall      (sclk_fall)
    );
    ws_edge_monitor u_ws (
        .pclk      (pclk),
        .presetn   (presetn),
        .line_in   (word_select_line),
        .line_sync (),
        .rise      (ws_rise),
        .fall      (ws_fall)
    );

    // edge parity, cleared while unit disabled
    logic edge_odd_q;
    wire logic sclk_edge = sclk_rise | sclk_fall;
    wire logic cap_w     = sclk_edge &
                           (phase_q ? edge_odd_q : ~edge_odd_q);
    wire logic ws_toggle = ws_rise | ws_fall;
    // toggle while clock high is misplaced
    wire logic ws_bad    = slave_audio_mode & ws_toggle &
                           ~sclk_fall & sclk_s;

    // ---------------------------------------------------------------
    // events and interrupt
    // ---------------------------------------------------------------
    wire logic [EV_WIDTH-1:0] ev_set = {ws_bad, err_any, receive_not_empty_flag_w, tbe_w};
    wire logic [EV_WIDTH-1:0] ev_clr =
        (wr_en & hit_st) ? pwdata[EV_WIDTH-1:0] : '0;
    wire logic [EV_WIDTH-1:0] stat_d = (stat_q & ~ev_clr) | ev_set;

    wire logic cond_w = (ctrl_q.transmit_empty_irq_enable & tbe_w)
                      | (ctrl_q.receive_not_empty_irq_enable & receive_not_empty_flag_w)
                      | (ctrl_q.error_irq_enable & err_any);
    wire logic irq_d  = cond_w | (|(stat_q & mask_q));

    // ---------------------------------------------------------------
    // control write with odd-count guard
    // ---------------------------------------------------------------
    wire logic [31:0] ctrl_word = {17'h0, ctrl_q};
    wire logic [31:0] wr_val    = pwdata & CTRL_WR_MASK;
    logic      [31:0] ctrl_new;
    always_comb
    begin
        ctrl_new = wr_val;
        if (unit_en_q || !SECOND_INSTANCE)
        begin
            ctrl_new[B_TX_ODD] = ctrl_word[B_TX_ODD];
            ctrl_new[B_RX_ODD] = ctrl_word[B_RX_ODD];
        end
    end

    wire logic [31:0] rd_mux =
        hit_ph  ? {30'h0, unit_en_q, phase_q} :
        hit_ctl ? ctrl_word :
        hit_st  ? {28'h0, stat_q} :
        hit_mk  ? {28'h0, mask_q} :
        hit_fv  ? {23'h0, rx_lvl, tx_lvl, fmt_err_q, err_any,
                   receive_not_empty_flag_w, tbe_w, irq} : 32'h0;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_q    <= ctrl_s'(CTRL_RST[14:0]);
            phase_q   <= 1'b0;
            unit_en_q <= 1'b0;
            stat_q    <= '0;
            mask_q    <= '0;
            fmt_err_q <= 1'b0;
            edge_odd_q <= 1'b0;
        end
        else
        begin
            if (wr_en && hit_ctl)
                ctrl_q <= ctrl_s'(ctrl_new[14:0]);
            if (wr_en && hit_ph)
            begin
                phase_q   <= pwdata[B_PHASE];
                unit_en_q <= pwdata[B_UNIT_EN];
            end
            if (wr_en && hit_mk)
                mask_q <= pwdata[EV_WIDTH-1:0];
            stat_q    <= stat_d;
            if (ws_bad)
                fmt_err_q <= 1'b1;
            else if (wr_en && hit_st && pwdata[EV_FMT])
                fmt_err_q <= 1'b0;
            if (!unit_en_q)
                edge_odd_q <= 1'b0;
            else if (sclk_edge)
                edge_odd_q <= ~edge_odd_q;
        end
    end

    // ---------------------------------------------------------------
    // registered outputs
    // ---------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata                  <= 32'h0;
            pready                  <= 1'b0;
            pslverr                 <= 1'b0;
            capture_strobe          <= 1'b0;
            frame_bits_m1           <= SIZE_FORCED;
            rx_fifo_level           <= LVL_EMPTY;
            tx_fifo_level           <= LVL_EMPTY;
            receive_not_empty_flag  <= 1'b0;
            transmit_empty_flag     <= 1'b0;
            frame_format_error_flag <= 1'b0;
            tx_odd_active           <= 1'b0;
            rx_odd_active           <= 1'b0;
            alt_frame_format        <= 1'b0;
            select_pulse_mode       <= 1'b0;
            select_out_n            <= 1'b1;
            select_oe_n             <= 1'b1;
            tx_dma_req              <= 1'b0;
            rx_dma_req              <= 1'b0;
            irq                     <= 1'b0;
        end
        else
        begin
            pready  <= psel & ~penable;
            pslverr <= psel & ~penable & ~mapped;
            if (psel && !penable && !pwrite)
                prdata <= rd_mux;
            capture_strobe          <= cap_w;
            frame_bits_m1           <= size_eff;
            rx_fifo_level           <= rx_lvl;
            tx_fifo_level           <= tx_lvl;
            receive_not_empty_flag  <= receive_not_empty_flag_w;
            transmit_empty_flag     <= tbe_w;
            frame_format_error_flag <= fmt_err_q;
            tx_odd_active  <= merge_mode & ctrl_q.tx_dma_request_enable &
                              ctrl_q.tx_dma_odd_count;
            rx_odd_active  <= merge_mode & ctrl_q.rx_dma_request_enable &
                              ctrl_q.rx_dma_odd_count;
            alt_frame_format  <= ctrl_q.alt_frame_format_enable;
            select_pulse_mode <= ctrl_q.select_pulse_enable;
            select_out_n      <= ~unit_en_q;
            select_oe_n       <= ~ctrl_q.select_output_drive;
            tx_dma_req <= ctrl_q.tx_dma_request_enable & tbe_w;
            rx_dma_req <= ctrl_q.rx_dma_request_enable & receive_not_empty_flag_w;
            irq        <= irq_d;
        end
    end
endmodule

// >>> testbench/spi_cfg_assertions.sv
// checker: port relations of the serial control slice
// assumes: bound to the top module, zero wait apb slave
`timescale 1ns/1ps
module spi_cfg_assertions
    import spi_cfg_pkg::*;
#(
    parameter bit SECOND_INSTANCE = 1'b1
)(
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [4:0]  err_flags_in,
    input wire logic [3:0]  frame_bits_m1,
    input wire logic        receive_not_empty_flag,
    input wire logic        transmit_empty_flag,
    input wire logic        alt_frame_format,
    input wire logic        select_pulse_mode,
    input wire logic        select_oe_n,
    input wire logic        tx_dma_req,
    input wire logic        rx_dma_req,
    input wire logic        irq
);
    // -----------------------------------------------------------------
    // shadow of the control word
    // -----------------------------------------------------------------
    logic [12:0] sh_q;
    logic [12:0] sh_d;
    logic [1:0]  quiet_q;
    logic [1:0]  quiet_d;
    wire         acc    = psel && penable;
    wire         wr_ctl = acc && pwrite && paddr == OFS_CONTROL;
    wire         calm   = quiet_q == 2'h3;
    wire         mapped = paddr inside {OFS_PHASE_CTRL, OFS_CONTROL,
                          OFS_IRQ_STATUS, OFS_IRQ_MASK, OFS_FLAG_VIEW};
    wire [3:0]   size_x = sh_q[11:8] < SIZE_MIN_CODE ? SIZE_FORCED
                          : sh_q[11:8];
    assign sh_d    = wr_ctl ? pwdata[12:0] : sh_q;
    assign quiet_d = wr_ctl ? 2'h0 : quiet_q + {1'b0, !calm};
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
        begin
            sh_q    <= SECOND_INSTANCE ? RST_CTRL_SECOND[12:0]
                       : RST_CTRL_FIRST[12:0];
            quiet_q <= 2'h0;
        end
        else
        begin
            sh_q    <= sh_d;
            quiet_q <= quiet_d;
        end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_ready_access: assert property (acc |-> pready)
        else $error("no pready in access");
    a_unmapped_err: assert property (acc && !mapped |-> pslverr)
        else $error("no error on unmapped");
    a_size_forced: assert property (calm |-> frame_bits_m1 == size_x)
        else $error("frame size wrong");
    a_alt_format: assert property (
        calm |-> alt_frame_format == sh_q[4])
        else $error("frame format wrong");
    a_pulse_mode: assert property (
        calm |-> select_pulse_mode == sh_q[3])
        else $error("pulse mode wrong");
    a_select_drive: assert property (calm |-> select_oe_n == !sh_q[2])
        else $error("select drive wrong");
    a_tx_dma_req: assert property (calm
        |-> tx_dma_req == (sh_q[1] && transmit_empty_flag))
        else $error("tx dma wrong");
    a_rx_dma_req: assert property (calm
        |-> rx_dma_req == (sh_q[0] && receive_not_empty_flag))
        else $error("rx dma wrong");
    a_err_irq: assert property (calm && sh_q[5] && |err_flags_in
        |-> ##[1:2] irq)
        else $error("no error interrupt");
    a_tbe_irq: assert property (calm && sh_q[7] && transmit_empty_flag
        |-> ##[0:1] irq)
        else $error("no tx empty interrupt");
    a_receive_not_empty_flag_irq: assert property (
        calm && sh_q[6] && receive_not_empty_flag |-> ##[0:1] irq)
        else $error("no rx interrupt");
    c_tx_req: cover property (tx_dma_req);
    c_rx_req: cover property (rx_dma_req);
    c_err_irq: cover property (sh_q[5] && irq);
    c_slverr: cover property (pslverr);
endmodule

bind spi_ctl_interrupt_dma_config spi_cfg_assertions #(
    .SECOND_INSTANCE(SECOND_INSTANCE)
) u_spi_cfg_assertions (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pready, .pslverr, .err_flags_in, .frame_bits_m1,
    .receive_not_empty_flag, .transmit_empty_flag, .alt_frame_format,
    .select_pulse_mode, .select_oe_n, .tx_dma_req, .rx_dma_req, .irq);

// >>> testbench/serial_far_end.sv
// partner: far serial device making clock and word select
// assumes: clock idles low and stands still between frames
`timescale 1ns/1ps
module serial_far_end (
    input  wire logic       start,
    input  wire logic [3:0] edges,
    input  wire logic       ws_bad,
    output logic            sck,
    output logic            ws,
    output logic            busy
);
    // -----------------------------------------------------------------
    // frame of clock edges, 48 ns period
    // -----------------------------------------------------------------
    initial
    begin
        sck  = 1'b0;
        ws   = 1'b0;
        busy = 1'b0;
    end
    always @(posedge start)
    begin
        busy = 1'b1;
        repeat (edges)
        begin
            #12;
            if (sck ? ws_bad : !ws_bad)
                ws = !ws;
            #12;
            sck = !sck;
        end
        busy = 1'b0;
    end
endmodule

// >>> testbench/spi_ctl_interrupt_dma_config_tb.sv
// bench: apb register, flag, dma, interrupt and pin scenarios
// assumes: second instance, fifo depth 4, zero wait apb
`timescale 1ns/1ps
module spi_ctl_interrupt_dma_config_tb
    import spi_cfg_pkg::*;
();
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err_q;
    logic        serial_clk_pin, word_select_line, slave_audio_mode;
    logic        data_write_16, tx_buf_empty, capture_strobe, irq;
    logic        receive_not_empty_flag, transmit_empty_flag;
    logic        frame_format_error_flag, tx_odd_active, rx_odd_active;
    logic        alt_frame_format, select_pulse_mode, select_out_n;
    logic        select_oe_n, tx_dma_req, rx_dma_req, start, ws_bad, busy;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd_q;
    logic [2:0]  rx_fifo_count, tx_fifo_count;
    logic [4:0]  err_flags_in;
    logic [3:0]  frame_bits_m1, edges;
    logic [1:0]  rx_fifo_level, tx_fifo_level;
    int          fail_count, checks_done, strobes;
    spi_ctl_interrupt_dma_config #(
        .SECOND_INSTANCE(1'b1),
        .FIFO_DEPTH(4),
        .CW(3)
    ) u_spi_ctl_interrupt_dma_config (.pclk, .presetn, .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .serial_clk_pin, .word_select_line, .slave_audio_mode,
        .data_write_16, .tx_buf_empty, .rx_fifo_count, .tx_fifo_count,
        .err_flags_in, .capture_strobe, .frame_bits_m1, .rx_fifo_level,
        .tx_fifo_level, .receive_not_empty_flag, .transmit_empty_flag,
        .frame_format_error_flag, .tx_odd_active, .rx_odd_active,
        .alt_frame_format, .select_pulse_mode, .select_out_n,
        .select_oe_n, .tx_dma_req, .rx_dma_req, .irq);
    serial_far_end u_serial_far_end (.start, .edges, .ws_bad,
        .sck(serial_clk_pin), .ws(word_select_line), .busy);
    // -----------------------------------------------------------------
    // clock, watchdog, helpers
    // -----------------------------------------------------------------
    initial
    begin
        pclk = 1'b0;
        forever #2.5 pclk = !pclk;
    end
    initial
    begin
        #100000;
        fail_count++;
        results();
    end
    always @(posedge pclk)
        if (capture_strobe === 1'b1)
            strobes++;
    task automatic results();
        if (fail_count == 0 && checks_done > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] s, e);
        checks_done++;
        if (s !== e)
        begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge pclk);
    endtask
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        rd_q = prdata;
        err_q = pslverr;
        {psel, penable} <= 2'h0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
        wt(4);
    endtask
    task automatic frame(input logic [3:0] n, input logic bad);
        edges  <= n;
        ws_bad <= bad;
        start  <= 1'b1;
        @(posedge pclk);
        start  <= 1'b0;
        while (busy !== 1'b0)
            @(posedge pclk);
        wt(4);
    endtask
    // -----------------------------------------------------------------
    // scenarios
    // -----------------------------------------------------------------
    task automatic t_regs();
        apb(1'b0, OFS_CONTROL, 32'h0);
        chk("ctl_reset", rd_q, RST_CTRL_SECOND);
        chk("size_reset", frame_bits_m1, 4'h7);
        apb(1'b0, 8'h0C, 32'h0);
        chk("unmapped_err", err_q, 1'b1);
        wr(OFS_CONTROL, 32'h7FFF);
        apb(1'b0, OFS_CONTROL, 32'h0);
        chk("ctl_all", rd_q, CTRL_WR_MASK);
        wr(OFS_PHASE_CTRL, 32'h2);
        wr(OFS_CONTROL, 32'h0);
        apb(1'b0, OFS_CONTROL, 32'h0);
        chk("odd_locked", rd_q, 32'h0000_6000);
        wr(OFS_PHASE_CTRL, 32'h0);
        wr(OFS_CONTROL, 32'h0);
        apb(1'b0, OFS_CONTROL, 32'h0);
        chk("odd_clear", rd_q, 32'h0);
    endtask
    task automatic t_size_modes();
        for (int c = 0; c < 16; c++)
        begin
            wr(OFS_CONTROL, {20'h0, c[3:0], 8'h0});
            chk("size", frame_bits_m1, c < 3 ? 4'h7 : c[3:0]);
        end
        for (int i = 2; i < 5; i++)
        begin
            wr(OFS_CONTROL, 32'h700 | (32'h1 << i));
            chk("alt_fmt", alt_frame_format, i == 4);
            chk("pulse", select_pulse_mode, i == 3);
            chk("sel_oe_n", select_oe_n, i != 2);
        end
    endtask
    task automatic t_flags();
        for (int b = 0; b < 2; b++)
            for (int c = 0; c < 3; c++)
            begin
                rx_fifo_count <= c[2:0];
                wr(OFS_CONTROL, 32'h741 | (b << 12));
                chk("receive_not_empty_flag", receive_not_empty_flag, c >= 2 - b);
                chk("rx_req", rx_dma_req, c >= 2 - b);
                chk("rx_irq", irq, c >= 2 - b);
            end
        rx_fifo_count <= 3'h0;
        for (int e = 0; e < 2; e++)
        begin
            tx_buf_empty  <= e[0];
            tx_fifo_count <= e[0] ? 3'h0 : 3'h3;
            wr(OFS_CONTROL, 32'h782);
            chk("tbe", transmit_empty_flag, e[0]);
            chk("tx_req", tx_dma_req, e[0]);
            chk("tx_irq", irq, e[0]);
        end
        for (int i = 0; i < 5; i++)
        begin
            err_flags_in <= 5'h1 << i;
            wr(OFS_CONTROL, 32'h720);
            chk("err_irq", irq, 1'b1);
            wr(OFS_CONTROL, 32'h700);
            chk("err_off", irq, 1'b0);
        end
        err_flags_in <= 5'h0;
    endtask
    task automatic t_levels();
        for (int c = 0; c < 5; c++)
        begin
            rx_fifo_count <= c[2:0];
            tx_fifo_count <= 3'(4 - c);
            wt(4);
            chk("rx_lvl", rx_fifo_level, c > 2 ? 2'h3 : c[1:0]);
            chk("tx_lvl", tx_fifo_level, c < 2 ? 2'h3 : 2'(4 - c));
        end
    endtask
    task automatic odd(input logic [31:0] d, input logic w, tx, rx);
        data_write_16 <= w;
        wr(OFS_CONTROL, d);
        chk("tx_odd", tx_odd_active, tx);
        chk("rx_odd", rx_odd_active, rx);
    endtask
    task automatic phase(input logic p, input int n);
        int s;
        wr(OFS_PHASE_CTRL, {30'h0, 1'b1, p});
        chk("sel_out", select_out_n, 1'b0);
        s = strobes;
        frame(4'h3, 1'b0);
        chk("strobes", strobes - s, n);
        wr(OFS_PHASE_CTRL, 32'h0);
        frame(4'h1, 1'b0);
    endtask
    task automatic t_format();
        slave_audio_mode <= 1'b1;
        frame(4'h2, 1'b0);
        chk("ws_good", frame_format_error_flag, 1'b0);
        frame(4'h2, 1'b1);
        chk("ws_bad", frame_format_error_flag, 1'b1);
        wr(OFS_IRQ_MASK, 32'h8);
        chk("mask_irq", irq, 1'b1);
        wr(OFS_IRQ_STATUS, 32'h8);
        chk("ws_clear", frame_format_error_flag, 1'b0);
        chk("clr_irq", irq, 1'b0);
    endtask
    initial
    begin
        {presetn, psel, penable, pwrite, start, ws_bad} = '0;
        {slave_audio_mode, data_write_16, tx_buf_empty} = '0;
        {paddr, pwdata, rx_fifo_count, tx_fifo_count} = '0;
        {err_flags_in, edges} = '0;
        {fail_count, checks_done, strobes} = '0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_size_modes();
        t_flags();
        t_levels();
        odd(32'h6703, 1'b1, 1'b1, 1'b1);
        odd(32'h6803, 1'b1, 1'b0, 1'b0);
        odd(32'h6701, 1'b1, 1'b0, 1'b1);
        odd(32'h6703, 1'b0, 1'b0, 1'b0);
        phase(1'b0, 2);
        phase(1'b1, 1);
        t_format();
        results();
    end
endmodule
